// ==== mcq_pkg.sv ====
`default_nettype none
package mcq_pkg;

    // Register byte offsets
    localparam int          ADDR_W        = 8;
    localparam int          DATA_W        = 32;
    localparam logic [7:0]  REG_CFG       = 8'h00;
    localparam logic [7:0]  REG_SEL       = 8'h04;
    localparam logic [7:0]  REG_DONE      = 8'h08;
    localparam logic [7:0]  REG_IRQ_STAT  = 8'h0C;
    localparam logic [7:0]  REG_IRQ_MASK  = 8'h10;
    localparam logic [7:0]  REG_DBAND     = 8'h14;

    // Field positions and widths
    localparam int          AXIS_ID_W     = 4;
    localparam int          CFG_AXIS_LSB  = 0;
    localparam int          CFG_CRIT_LSB  = 8;
    localparam int          CRIT_W        = 5;
    localparam int          CFG_DELAY_LSB = 16;
    localparam int          CFG_PULSE_LSB = 24;
    localparam int          MS_W          = 8;
    localparam int          DBAND_LSB     = 16;
    localparam int          DBAND_W       = 16;
    localparam int          POS_W         = 32;
    localparam int          STAT_W        = 16;

    // Criteria bit indices
    localparam int          CRIT_PROFILE  = 0;
    localparam int          CRIT_MOTOR    = 1;
    localparam int          CRIT_STOP     = 2;
    localparam int          CRIT_DELAY    = 3;
    localparam int          CRIT_INPOS    = 4;

    // Reset values
    localparam logic [CRIT_W-1:0]  CRIT_FORCED = 5'h01;
    localparam logic [MS_W-1:0]    DELAY_RST   = 8'h00;
    localparam logic [MS_W-1:0]    PULSE_RST   = 8'h00;
    localparam logic [DBAND_W-1:0] DBAND_RST   = 16'h0000;

    localparam logic [AXIS_ID_W-1:0] MIN_AXIS_ID = 4'h1;
    localparam logic [AXIS_ID_W-1:0] TOP_AXIS_ID = 4'hF;
    localparam logic [1:0]  RESP_OKAY     = 2'h0;
    localparam logic [1:0]  RESP_SLVERR   = 2'h2;
    localparam logic [3:0]  WSTRB_ALL     = 4'hF;

    // Millisecond timebase
    localparam int          CLK_PERIOD_NS = 4;
    localparam int          MS_PERIOD_NS  = 1000000;
    localparam int          CYC_PER_MS    = MS_PERIOD_NS / CLK_PERIOD_NS;

    typedef struct packed {
        logic [CRIT_W-1:0]  crit;
        logic [MS_W-1:0]    delay_ms;
        logic [MS_W-1:0]    pulse_ms;
        logic [DBAND_W-1:0] deadband;
    } mcq_cfg_type;

    localparam mcq_cfg_type CFG_RST = '{crit: CRIT_FORCED,
        delay_ms: DELAY_RST, pulse_ms: PULSE_RST, deadband: DBAND_RST};

    typedef struct packed {
        logic               profile_done;
        logic               motor_off;
        logic               run_stopped;
        logic               move_start;
        logic [POS_W-1:0]   act_pos;
        logic [POS_W-1:0]   tgt_pos;
    } mcq_axis_in_type;

endpackage
`default_nettype wire

// ==== mcq_axis.sv ====
`default_nettype none
module mcq_axis
    import mcq_pkg::*;
(
    input  wire logic            core_clk,
    input  wire logic            resetn,
    input  wire logic            ms_tick,
    input  wire mcq_cfg_type     cfg,
    input  wire mcq_axis_in_type ain,
    output logic                 done_q
);

    logic [POS_W:0] diff;
    logic [POS_W:0] mag;
    logic           in_pos;
    logic           base;
    logic           qual;
    logic           met;
    logic           clr;
    logic [MS_W:0]  dly_lim;
    logic [MS_W:0]  dly_cnt_q;
    logic [MS_W:0]  pulse_cnt_q;
    logic           start_pend_q;

    assign diff = {ain.act_pos[POS_W-1], ain.act_pos}
                - {ain.tgt_pos[POS_W-1], ain.tgt_pos};
    assign mag = diff[POS_W] ? -diff : diff;
    // Strictly inside the band
    assign in_pos = mag < {{(POS_W + 1 - DBAND_W){1'b0}}, cfg.deadband};

    assign base = ain.profile_done
                | (cfg.crit[CRIT_MOTOR] & ain.motor_off);
    assign qual = base
                & (~cfg.crit[CRIT_STOP] | ain.run_stopped)
                & (~cfg.crit[CRIT_INPOS] | in_pos);
    // One extra tick so a wait is never shorter than programmed
    assign dly_lim = {1'b0, cfg.delay_ms} + {{MS_W{1'b0}}, 1'b1};
    assign met = qual & (~cfg.crit[CRIT_DELAY] | (cfg.delay_ms == '0)
               | (dly_cnt_q >= dly_lim));
    assign clr = done_q & (pulse_cnt_q == '0)
               & (ain.move_start | start_pend_q);

    always_ff @(posedge core_clk or negedge resetn)
    begin
        if (!resetn)
            dly_cnt_q <= '0;
        else if (!qual || !cfg.crit[CRIT_DELAY])
            dly_cnt_q <= '0;
        else if (ms_tick && dly_cnt_q < dly_lim)
            dly_cnt_q <= dly_cnt_q + {{MS_W{1'b0}}, 1'b1};
    end

    always_ff @(posedge core_clk or negedge resetn)
    begin
        if (!resetn)
            done_q <= 1'b0;
        else if (clr)
            done_q <= 1'b0;
        else if (met)
            done_q <= 1'b1;
    end

    always_ff @(posedge core_clk or negedge resetn)
    begin
        if (!resetn)
            pulse_cnt_q <= '0;
        else if (met && !done_q)
            pulse_cnt_q <= (cfg.pulse_ms == '0) ? '0
                : {1'b0, cfg.pulse_ms} + {{MS_W{1'b0}}, 1'b1};
        else if (ms_tick && pulse_cnt_q != '0)
            pulse_cnt_q <= pulse_cnt_q - {{MS_W{1'b0}}, 1'b1};
    end

    // A restart inside the pulse is remembered, not dropped
    always_ff @(posedge core_clk or negedge resetn)
    begin
        if (!resetn)
            start_pend_q <= 1'b0;
        else if (clr || !done_q)
            start_pend_q <= 1'b0;
        else if (ain.move_start && pulse_cnt_q != '0)
            start_pend_q <= 1'b1;
    end

    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!resetn);

    AST_PROFILE_DONE: assert property (ain.profile_done
        && !cfg.crit[CRIT_STOP] && !cfg.crit[CRIT_DELAY]
        && !cfg.crit[CRIT_INPOS] && !clr |=> done_q)
        else $error("profile done did not set completion");
    AST_MOTOR_OFF: assert property (ain.motor_off && cfg.crit[CRIT_MOTOR]
        && !cfg.crit[CRIT_STOP] && !cfg.crit[CRIT_DELAY]
        && !cfg.crit[CRIT_INPOS] && !clr |=> done_q)
        else $error("motor off did not set completion");
    AST_NO_BASE: assert property (!ain.profile_done
        && !(cfg.crit[CRIT_MOTOR] && ain.motor_off) && !done_q
        |=> !done_q)
        else $error("completion without base condition");
    AST_STOP_GATE: assert property (cfg.crit[CRIT_STOP] && !ain.run_stopped
        && !done_q |=> !done_q)
        else $error("completion while axis running");
    AST_INPOS_GATE: assert property (cfg.crit[CRIT_INPOS] && !in_pos
        && !done_q |=> !done_q)
        else $error("completion outside deadband");
    AST_DELAY_WAIT: assert property (cfg.crit[CRIT_DELAY]
        && cfg.delay_ms != '0 && $rose(qual) && !done_q
        |=> !done_q [*2])
        else $error("settling delay skipped");
    AST_DELAY_RESTART: assert property (cfg.crit[CRIT_DELAY] && !qual
        |=> dly_cnt_q == '0)
        else $error("settling delay not restarted");
    AST_MIN_PULSE: assert property (done_q && pulse_cnt_q != '0
        |=> done_q)
        else $error("completion dropped inside minimum pulse");
    AST_CLEAR: assert property (done_q && pulse_cnt_q == '0
        && ain.move_start |=> !done_q)
        else $error("completion not cleared on new move");
    AST_PULSE_LOAD: assert property ($rose(done_q) |-> pulse_cnt_q
        == (($past(cfg.pulse_ms) == 8'h00) ? 9'h000
        : {1'b0, $past(cfg.pulse_ms)} + 9'h001))
        else $error("minimum pulse count loaded wrong");

    COV_DELAYED: cover property (cfg.crit[CRIT_DELAY]
        && cfg.delay_ms != '0 && $rose(done_q));
    COV_RESTART_IN_PULSE: cover property (done_q && ain.move_start
        && pulse_cnt_q != '0 ##1 start_pend_q);
    COV_MOTOR_OFF: cover property (!ain.profile_done && ain.motor_off
        && cfg.crit[CRIT_MOTOR] ##1 done_q);

endmodule
`default_nettype wire

// ==== mcq_top.sv ====
// How it works
// - Configuration names an axis 1 to 15; absent axes drop it.
// - A write to an absent axis changes nothing and answers without fault.
// - An axis meeting its criteria sets its own bit of move_done_status_reg.
// - Each axis keeps a five-bit map: profile, motor, stop, delay, in-pos.
// - The base condition is profile done OR (if enabled) motor off.
// - The profile-done criterion always reads one and is met at profile end.
// - With motor-off enabled any motor shutdown (kill, trip) meets the base.
// - Stop, delay and in-position criteria, when enabled, AND with the base.
// - With stop enabled the axis must also be logically stopped.
// - With delay enabled the settling delay follows all other criteria.
// - The settling delay is 0 to 255 ms and resets to 0.
// - With in-position on, |error| must be strictly below the deadband.
// - Completion holds for the minimum pulse even if the axis restarts.
// - The minimum pulse time is 0 to 255 ms and resets to 0.
`default_nettype none
module mcq_top
    import mcq_pkg::*;
#(
    parameter int          NUM_AXES  = 8,
    parameter int unsigned MS_CYCLES = CYC_PER_MS
)
(
    input  wire logic                           core_clk,
    input  wire logic                           resetn,
    input  wire logic [ADDR_W-1:0]              s_axi_awaddr,
    input  wire logic                           s_axi_awvalid,
    output logic                                s_axi_awready,
    input  wire logic [DATA_W-1:0]              s_axi_wdata,
    input  wire logic [3:0]                     s_axi_wstrb,
    input  wire logic                           s_axi_wvalid,
    output logic                                s_axi_wready,
    output logic [1:0]                          s_axi_bresp,
    output logic                                s_axi_bvalid,
    input  wire logic                           s_axi_bready,
    input  wire logic [ADDR_W-1:0]              s_axi_araddr,
    input  wire logic                           s_axi_arvalid,
    output logic                                s_axi_arready,
    output logic [DATA_W-1:0]                   s_axi_rdata,
    output logic [1:0]                          s_axi_rresp,
    output logic                                s_axi_rvalid,
    input  wire logic                           s_axi_rready,
    input  wire mcq_axis_in_type [NUM_AXES:1]   axis_in,
    output logic [NUM_AXES:1]                   move_done,
    output logic                                irq
);

    localparam int TW = $clog2(MS_CYCLES + 1);

    function automatic logic axis_ok(input logic [AXIS_ID_W-1:0] id);
        return (id >= MIN_AXIS_ID) && (id <= TOP_AXIS_ID)
            && (int'(id) <= NUM_AXES);
    endfunction

    function automatic logic addr_known(input logic [ADDR_W-1:0] a);
        logic ok;
        if (a == REG_CFG)
            ok = 1'b1;
        else if (a == REG_SEL)
            ok = 1'b1;
        else if (a == REG_DONE)
            ok = 1'b1;
        else if (a == REG_IRQ_STAT)
            ok = 1'b1;
        else if (a == REG_IRQ_MASK)
            ok = 1'b1;
        else if (a == REG_DBAND)
            ok = 1'b1;
        else
            ok = 1'b0;
        return ok;
    endfunction

    logic [TW-1:0]          tick_cnt_q;
    logic                   ms_tick;
    logic                   aw_have_q;
    logic [ADDR_W-1:0]      awaddr_q;
    logic                   w_have_q;
    logic [DATA_W-1:0]      wdata_q;
    logic [3:0]             wstrb_q;
    logic                   do_write;
    logic                   wr_full;
    logic [AXIS_ID_W-1:0]   wr_id;
    logic                   cfg_wr;
    logic                   dband_wr;
    logic                   ar_take;
    logic [AXIS_ID_W-1:0]   sel_q;
    logic [STAT_W-1:0]      mask_q;
    logic [STAT_W-1:0]      irq_stat_q;
    logic [STAT_W-1:0]      done_vec;
    logic [STAT_W-1:0]      done_prev_q;
    logic [DATA_W-1:0]      rdata_d;
    logic [NUM_AXES:1]      cfg_we;
    logic [NUM_AXES:1]      dband_we;
    mcq_cfg_type            cfg_all [NUM_AXES:1];
    mcq_cfg_type            cfg_sel;

    // Shared millisecond timebase for every axis
    always_ff @(posedge core_clk or negedge resetn)
    begin
        if (!resetn)
            tick_cnt_q <= '0;
        else if (ms_tick)
            tick_cnt_q <= '0;
        else
            tick_cnt_q <= tick_cnt_q + {{(TW - 1){1'b0}}, 1'b1};
    end
    assign ms_tick = (tick_cnt_q == TW'(MS_CYCLES - 1));

    // Write address and data are accepted in either order
    assign s_axi_awready = !aw_have_q;
    assign s_axi_wready  = !w_have_q;
    assign do_write      = aw_have_q && w_have_q && !s_axi_bvalid;

    always_ff @(posedge core_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            aw_have_q <= 1'b0;
            awaddr_q  <= '0;
        end
        else if (s_axi_awvalid && s_axi_awready)
        begin
            aw_have_q <= 1'b1;
            awaddr_q  <= s_axi_awaddr;
        end
        else if (do_write)
            aw_have_q <= 1'b0;
    end

    always_ff @(posedge core_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            w_have_q <= 1'b0;
            wdata_q  <= '0;
            wstrb_q  <= '0;
        end
        else if (s_axi_wvalid && s_axi_wready)
        begin
            w_have_q <= 1'b1;
            wdata_q  <= s_axi_wdata;
            wstrb_q  <= s_axi_wstrb;
        end
        else if (do_write)
            w_have_q <= 1'b0;
    end

    always_ff @(posedge core_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= RESP_OKAY;
        end
        else if (do_write)
        begin
            s_axi_bvalid <= 1'b1;
            // Absent axis is not a fault
            s_axi_bresp  <= addr_known(awaddr_q) ? RESP_OKAY
                                                 : RESP_SLVERR;
        end
        else if (s_axi_bready)
            s_axi_bvalid <= 1'b0;
    end

    // Commit registers take whole words only, so a torn id cannot land
    assign wr_full  = (wstrb_q == WSTRB_ALL);
    assign wr_id    = wdata_q[CFG_AXIS_LSB +: AXIS_ID_W];
    assign cfg_wr   = do_write && wr_full && (awaddr_q == REG_CFG)
                   && axis_ok(wr_id);
    assign dband_wr = do_write && wr_full && (awaddr_q == REG_DBAND)
                   && axis_ok(wr_id);

    genvar gi;
    generate
        for (gi = 1; gi <= NUM_AXES; gi++)
        begin : g_axis
            mcq_cfg_type cfg_q;

            assign cfg_we[gi]   = cfg_wr && (int'(wr_id) == gi);
            assign dband_we[gi] = dband_wr && (int'(wr_id) == gi);

            always_ff @(posedge core_clk or negedge resetn)
            begin
                if (!resetn)
                    cfg_q <= CFG_RST;
                else if (cfg_we[gi])
                begin
                    cfg_q.crit     <= wdata_q[CFG_CRIT_LSB +: CRIT_W]
                                    | CRIT_FORCED;
                    cfg_q.delay_ms <= wdata_q[CFG_DELAY_LSB +: MS_W];
                    cfg_q.pulse_ms <= wdata_q[CFG_PULSE_LSB +: MS_W];
                end
                else if (dband_we[gi])
                    cfg_q.deadband <= wdata_q[DBAND_LSB +: DBAND_W];
            end
            assign cfg_all[gi] = cfg_q;

            mcq_axis u_axis (
                .core_clk (core_clk),
                .resetn   (resetn),
                .ms_tick  (ms_tick),
                .cfg      (cfg_q),
                .ain      (axis_in[gi]),
                .done_q   (move_done[gi])
            );
        end
    endgenerate

    always_comb
    begin
        done_vec = '0;
        for (int i = 1; i <= NUM_AXES; i++)
            done_vec[i] = move_done[i];
    end

    always_ff @(posedge core_clk or negedge resetn)
    begin
        if (!resetn)
            sel_q <= '0;
        else if (do_write && awaddr_q == REG_SEL && wstrb_q[0])
            sel_q <= wdata_q[AXIS_ID_W-1:0];
    end

    always_ff @(posedge core_clk or negedge resetn)
    begin
        if (!resetn)
            mask_q <= '0;
        else if (do_write && awaddr_q == REG_IRQ_MASK)
        begin
            if (wstrb_q[0])
                mask_q[7:0] <= wdata_q[7:0];
            if (wstrb_q[1])
                mask_q[15:8] <= wdata_q[15:8];
        end
    end

    // Completion edges latch; read clears, a new edge wins over the clear
    assign ar_take = s_axi_arvalid && s_axi_arready;
    always_ff @(posedge core_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            done_prev_q <= '0;
            irq_stat_q  <= '0;
        end
        else
        begin
            done_prev_q <= done_vec;
            irq_stat_q  <= (irq_stat_q
                & ~{STAT_W{ar_take && s_axi_araddr == REG_IRQ_STAT}})
                | (done_vec & ~done_prev_q);
        end
    end
    assign irq = |(irq_stat_q & mask_q);

    always_comb
    begin
        cfg_sel = CFG_RST;
        for (int i = 1; i <= NUM_AXES; i++)
            if (int'(sel_q) == i)
                cfg_sel = cfg_all[i];
    end

    always_comb
    begin
        rdata_d = '0;
        if (s_axi_araddr == REG_CFG)
        begin
            if (axis_ok(sel_q))
            begin
                rdata_d[CFG_AXIS_LSB +: AXIS_ID_W] = sel_q;
                rdata_d[CFG_CRIT_LSB +: CRIT_W] =
                    cfg_sel.crit | CRIT_FORCED;
                rdata_d[CFG_DELAY_LSB +: MS_W] = cfg_sel.delay_ms;
                rdata_d[CFG_PULSE_LSB +: MS_W] = cfg_sel.pulse_ms;
            end
        end
        else if (s_axi_araddr == REG_SEL)
            rdata_d[AXIS_ID_W-1:0] = sel_q;
        else if (s_axi_araddr == REG_DONE)
            rdata_d[STAT_W-1:0] = done_vec;
        else if (s_axi_araddr == REG_IRQ_STAT)
            rdata_d[STAT_W-1:0] = irq_stat_q;
        else if (s_axi_araddr == REG_IRQ_MASK)
            rdata_d[STAT_W-1:0] = mask_q;
        else if (s_axi_araddr == REG_DBAND)
        begin
            if (axis_ok(sel_q))
            begin
                rdata_d[CFG_AXIS_LSB +: AXIS_ID_W] = sel_q;
                rdata_d[DBAND_LSB +: DBAND_W] = cfg_sel.deadband;
            end
        end
    end

    assign s_axi_arready = !s_axi_rvalid;
    always_ff @(posedge core_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= '0;
            s_axi_rresp  <= RESP_OKAY;
        end
        else if (ar_take)
        begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata  <= rdata_d;
            s_axi_rresp  <= addr_known(s_axi_araddr) ? RESP_OKAY
                                                     : RESP_SLVERR;
        end
        else if (s_axi_rready)
            s_axi_rvalid <= 1'b0;
    end

    AST_BAD_AXIS_IGNORED: assert property (@(posedge core_clk)
        disable iff (!resetn)
        do_write && !axis_ok(wr_id) |-> cfg_we == '0 && dband_we == '0)
        else $error("write to absent axis reached a config");
    AST_BAD_AXIS_OKAY: assert property (@(posedge core_clk)
        disable iff (!resetn)
        do_write && (awaddr_q == REG_CFG) && !axis_ok(wr_id)
        |=> s_axi_bvalid && s_axi_bresp == RESP_OKAY)
        else $error("absent axis write answered with fault");
    AST_STATUS_READ: assert property (@(posedge core_clk)
        disable iff (!resetn)
        ar_take && s_axi_araddr == REG_DONE
        |=> s_axi_rdata[STAT_W-1:0] == $past(done_vec))
        else $error("status read does not show completion bits");

    COV_BAD_AXIS: cover property (@(posedge core_clk)
        disable iff (!resetn) do_write && !axis_ok(wr_id));
    COV_IRQ: cover property (@(posedge core_clk)
        disable iff (!resetn) $rose(irq));

endmodule
`default_nettype wire

// ==== tb_mcq_top.sv ====
`default_nettype none
module tb_mcq_top
    import mcq_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic                  core_clk, resetn, irq;
    logic [7:0]            awaddr, araddr;
    logic [31:0]           wdata, rdata, rv;
    logic [3:0]            wstrb;
    logic [1:0]            bresp, rresp, rs;
    logic                  awvalid, awready, wvalid, wready, bvalid, bready;
    logic                  arvalid, arready, rvalid, rready;
    mcq_axis_in_type [8:1] ain;
    logic [8:1]            done;
    int                    fails, checks;

    mcq_top #(.NUM_AXES(8), .MS_CYCLES(10)) mcq_top_i (
        .core_clk(core_clk), .resetn(resetn), .s_axi_awaddr(awaddr),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
        .s_axi_bready(bready), .s_axi_araddr(araddr),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready), .axis_in(ain), .move_done(done), .irq(irq));

    initial
    begin
        core_clk = 1'b0;
        forever #2 core_clk = ~core_clk;
    end

    task automatic chk(input string nm, input logic [31:0] s, e);
        checks++;
        if (s !== e)
        begin
            fails++;
            $display("Error %s exp %h got %h", nm, e, s);
        end
    endtask

    task automatic final_report();
        $display("checks %0d fails %0d", checks, fails);
        if (fails == 0 && checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask

    // Handshake decided at negedge, where both sides are settled
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic ta, tw, tb;
        @(posedge core_clk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do
        begin
            @(negedge core_clk);
            ta = awvalid & awready;
            tw = wvalid & wready;
            tb = bvalid;
            rs = bresp;
            @(posedge core_clk);
            if (ta)
                awvalid <= 1'b0;
            if (tw)
                wvalid <= 1'b0;
        end
        while (tb !== 1'b1);
        bready <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a);
        logic ta, tr;
        @(posedge core_clk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do
        begin
            @(negedge core_clk);
            ta = arvalid & arready;
            tr = rvalid;
            rv = rdata;
            rs = rresp;
            @(posedge core_clk);
            if (ta)
                arvalid <= 1'b0;
        end
        while (tr !== 1'b1);
        rready <= 1'b0;
    endtask

    function automatic logic [31:0] cf(input logic [3:0] id,
        input logic [4:0] c, input logic [7:0] dl, pl);
        return {pl, dl, 3'h0, c, 4'h0, id};
    endfunction

    task automatic t_cfg();
        chk("done", {24'h0, done}, 32'h0);
        wr(REG_SEL, 32'h1);
        rd(REG_CFG);
        chk("cfg", rv, 32'h0000_0101);
        wr(REG_CFG, cf(4'h1, 5'h00, 8'h00, 8'h00));
        rd(REG_CFG);
        chk("crit", rv, 32'h0000_0101);
        wr(REG_CFG, cf(4'h1, 5'h1F, 8'hFF, 8'hFF));
        rd(REG_CFG);
        chk("cfg", rv, 32'hFFFF_1F01);
        wr(REG_CFG, cf(4'h1, 5'h01, 8'h00, 8'h00));
        wr(REG_CFG, cf(4'h9, 5'h1F, 8'h05, 8'h05));
        chk("bresp", rs, RESP_OKAY);
        wr(REG_CFG, cf(4'h0, 5'h1F, 8'h05, 8'h05));
        rd(REG_CFG);
        chk("cfg", rv, 32'h0000_0101);
        wr(8'h18, 32'hFFFF_FFFF);
        chk("bresp", rs, RESP_SLVERR);
        rd(8'h18);
        chk("rresp", rs, RESP_SLVERR);
        wr(REG_SEL, 32'h9);
        rd(REG_CFG);
        chk("cfg", rv, 32'h0);
        $display("test cfg done");
    endtask

    task automatic t_base();
        wr(REG_IRQ_MASK, 32'h0);
        @(posedge core_clk);
        ain[1].profile_done <= 1'b1;
        cyc(3);
        chk("done1", done[1], 1'b1);
        rd(REG_DONE);
        chk("status", rv, 32'h2);
        chk("irq", irq, 1'b0);
        wr(REG_IRQ_MASK, 32'h2);
        #1;
        chk("irq", irq, 1'b1);
        rd(REG_IRQ_STAT);
        chk("stat", rv, 32'h2);
        #1;
        chk("irq", irq, 1'b0);
        @(posedge core_clk);
        ain[1].profile_done <= 1'b0;
        ain[1].move_start <= 1'b1;
        @(posedge core_clk);
        ain[1].move_start <= 1'b0;
        cyc(2);
        chk("done1", done[1], 1'b0);
        $display("test base done");
    endtask

    task automatic t_qual();
        @(posedge core_clk);
        ain[2].motor_off <= 1'b1;
        cyc(5);
        chk("done2", done[2], 1'b0);
        wr(REG_CFG, cf(4'h2, 5'h03, 8'h00, 8'h00));
        cyc(3);
        chk("done2", done[2], 1'b1);
        wr(REG_CFG, cf(4'h3, 5'h05, 8'h00, 8'h00));
        ain[3].profile_done <= 1'b1;
        cyc(5);
        chk("done3", done[3], 1'b0);
        @(posedge core_clk);
        ain[3].run_stopped <= 1'b1;
        cyc(3);
        chk("done3", done[3], 1'b1);
        wr(REG_DBAND, {16'h0005, 16'h0004});
        wr(REG_SEL, 32'h4);
        rd(REG_DBAND);
        chk("dband", rv, 32'h0005_0004);
        wr(REG_CFG, cf(4'h4, 5'h11, 8'h00, 8'h00));
        ain[4].act_pos <= 32'h0000_0064;
        ain[4].tgt_pos <= 32'h0000_0069;
        ain[4].profile_done <= 1'b1;
        cyc(5);
        chk("done4", done[4], 1'b0);
        @(posedge core_clk);
        ain[4].tgt_pos <= 32'h0000_0060;
        cyc(3);
        chk("done4", done[4], 1'b1);
        $display("test qual done");
    endtask

    // 2 ms delay is 21 to 30 cycles; a drop at 16 restarts it
    task automatic t_time();
        wr(REG_CFG, cf(4'h5, 5'h09, 8'h02, 8'h00));
        ain[5].profile_done <= 1'b1;
        repeat (16) @(posedge core_clk);
        ain[5].profile_done <= 1'b0;
        repeat (3) @(posedge core_clk);
        ain[5].profile_done <= 1'b1;
        cyc(19);
        chk("done5", done[5], 1'b0);
        cyc(14);
        chk("done5", done[5], 1'b1);
        wr(REG_CFG, cf(4'h6, 5'h01, 8'h00, 8'h02));
        ain[6].profile_done <= 1'b1;
        repeat (3) @(posedge core_clk);
        ain[6].profile_done <= 1'b0;
        ain[6].move_start <= 1'b1;
        @(posedge core_clk);
        ain[6].move_start <= 1'b0;
        cyc(14);
        chk("done6", done[6], 1'b1);
        cyc(20);
        chk("done6", done[6], 1'b0);
        $display("test time done");
    endtask

    initial
    begin
        #40000;
        fails++;
        final_report();
    end

    initial
    begin
        {resetn, awvalid, wvalid, bready, arvalid, rready} = '0;
        {awaddr, araddr, wdata} = '0;
        wstrb = WSTRB_ALL;
        ain = '0;
        repeat (20) @(posedge core_clk);
        resetn <= 1'b1;
        t_cfg();
        t_base();
        t_qual();
        t_time();
        final_report();
    end
endmodule
`default_nettype wire
